/* File: rtl/spm_link_side.sv */
// link-clock logic: frame slot counter, slot mapping and configuration pickup
`timescale 1ns/1ps
`include "spm_regs.svh"
module spm_link_side
(
  // link clock and reset
  input  wire logic                link_clk,
  input  wire logic                arst_n,
  // frame marker from the link
  input  wire logic                frame_sync,
  // shadow configuration from the bus domain, stable while req toggles
  input  wire logic                cfg_req_tgl,
  input  wire spm_pkg::spm_slot_t  cfg_slots,
  input  wire logic                cfg_active,
  output logic                     cfg_ack_tgl,
  // port data
  input  wire logic                tx_bit,
  output logic                     rx_bit,
  // link slot stream
  input  wire logic                link_rx_bit,
  output logic                     link_tx_bit,
  output logic                     slot_claim,
  output logic [4:0]               slot_index
);

  logic [2:0]         req_sync_reg;
  logic [31:0]        slots_reg;
  logic               active_reg;
  logic               take;
  logic [4:0]         slot_next;
  logic [31:0]        slots_next;
  logic               active_next;
  logic               claim;

  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
      req_sync_reg <= 3'h0;
    else
      req_sync_reg <= {req_sync_reg[1:0], cfg_req_tgl};
  end

  // slot counter restarts on the frame marker
  always_comb
  begin
    slot_next = slot_index;
    if (frame_sync)
      slot_next = 5'h00;
    else if (slot_index != `SPM_FRAME_SLOTS)
      slot_next = slot_index + 5'h01;
  end

  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
      slot_index <= 5'h00;
    else
      slot_index <= slot_next;
  end

  // new set taken whole, only on a frame boundary
  assign take = frame_sync && (req_sync_reg[2] != cfg_ack_tgl)
                && (req_sync_reg[1] == req_sync_reg[2]);

  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      slots_reg   <= 32'h0000_0000;
      active_reg  <= 1'b0;
      cfg_ack_tgl <= 1'b0;
    end
    else if (take)
    begin
      slots_reg   <= cfg_slots;
      active_reg  <= cfg_active;
      cfg_ack_tgl <= req_sync_reg[2];
    end
  end

  // claim for the slot being entered, in step with slot_index
  assign slots_next  = take ? cfg_slots : slots_reg;
  assign active_next = take ? cfg_active : active_reg;
  assign claim       = active_next && slots_next[slot_next];

  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      slot_claim  <= 1'b0;
      link_tx_bit <= 1'b0;
      rx_bit      <= 1'b0;
    end
    else
    begin
      slot_claim  <= claim;
      link_tx_bit <= claim ? tx_bit : 1'b0;
      // receive bit taken as a claimed slot ends
      if (slot_claim)
        rx_bit <= link_rx_bit;
    end
  end

endmodule

/* File: rtl/spm_sync3.sv */
// three-stage input synchroniser, accepting a change once stages two and three agree
`timescale 1ns/1ps
`include "spm_regs.svh"
module spm_sync3
(
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // level in and out
  input  wire logic din,
  output logic      dout
);

  logic [2:0] stage_reg;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      stage_reg <= 3'h0;
    else
      stage_reg <= {stage_reg[1:0], din};
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      dout <= 1'b0;
    else if (stage_reg[1] == stage_reg[2])
      dout <= stage_reg[2];
  end

endmodule

/* File: rtl/spm_top.sv */
// serial port slot mapper: APB registers, control leads and link-side mapping
`timescale 1ns/1ps
`include "spm_regs.svh"
module spm_top
(
  // system clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // link side
  input  wire logic        link_clk,
  input  wire logic        frame_sync,
  input  wire logic        link_rx_bit,
  output logic             link_tx_bit,
  output logic             slot_claim,
  output logic [4:0]       slot_index,
  // link and system status pins
  input  wire logic        link_up_pin,
  input  wire logic        pri_link_pin,
  // serial port pins
  input  wire logic        tx_data,
  output logic             rx_data,
  input  wire logic        rts_local,
  input  wire logic        rts_remote,
  output logic             rlsd,
  output logic             dsr,
  output logic             cts,
  output logic             dte_mode
);

  //////////////////////////////////////////////////////////////////////////////
  // decode

  function automatic logic [3:0] spm_card_limit(input logic [2:0] code);
    spm_card_limit = (code == 3'h4) ? 4'd4 : 4'd2;
  endfunction

  function automatic logic slot_legal(input logic [4:0] s, input logic e1, input logic sig);
    logic [4:0] top;
    top = e1 ? `SPM_E1_SLOTS : `SPM_T1_SLOTS;
    slot_legal = (s >= 5'd1) && (s <= top) && !(e1 && sig && s == `SPM_E1_SIG_SLOT);
  endfunction

  function automatic logic [5:0] spm_reg_hit(input logic [11:0] a);
    spm_reg_hit[0] = (a == `SPM_OFS_CTRL);
    spm_reg_hit[1] = (a == `SPM_OFS_DEST);
    spm_reg_hit[2] = (a == `SPM_OFS_SLOTS);
    spm_reg_hit[3] = (a == `SPM_OFS_LOOP);
    spm_reg_hit[4] = (a == `SPM_OFS_COMMIT);
    spm_reg_hit[5] = (a == `SPM_OFS_STATUS);
  endfunction

  logic        acc_en;
  logic        wr_en;
  logic        addr_ok;
  logic [5:0]  hit;
  logic        wr_ctrl;
  logic        wr_dest;
  logic        wr_slots;
  logic        wr_loop;
  logic        wr_commit;
  logic [31:0] ctrl_reg;
  logic [31:0] dest_reg;
  logic [31:0] slots_reg;
  logic [31:0] loop_reg;
  logic [31:0] slot_mask;
  logic [31:0] rd_val;
  logic        req_tgl_reg;
  logic [2:0]  ack_sync_reg;
  logic        link_up_s;
  logic        pri_s;
  logic        rts_loc_s;
  logic        rts_rem_s;
  logic [3:0]  pin_raw;
  logic [3:0]  pin_s;
  logic        tx_s;
  logic        ack_tgl;
  logic [31:0] sh_slots_reg;
  logic        sh_active_reg;
  logic        pend;
  logic        active;
  logic [3:0]  req_port;
  logic [3:0]  eff_port;
  logic [2:0]  wan_q;
  logic [1:0]  sty_q;
  logic [2:0]  snd_w;
  logic [2:0]  snd_ok;
  logic        rx_link;

  assign acc_en  = psel && penable;
  assign pready  = 1'b1;
  assign hit       = spm_reg_hit(paddr);
  assign addr_ok   = |hit;
  assign pslverr   = acc_en && !addr_ok;
  assign wr_en     = acc_en && pwrite && addr_ok;
  assign wr_ctrl   = wr_en && hit[0];
  assign wr_dest   = wr_en && hit[1];
  assign wr_slots  = wr_en && hit[2];
  assign wr_loop   = wr_en && hit[3];
  assign wr_commit = wr_en && hit[4];

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  assign pin_raw = {rts_remote, rts_local, pri_link_pin, link_up_pin};

  genvar si;
  generate
    for (si = 0; si < 4; si++)
    begin : g_sync
      spm_sync3 u_sync
      (
        .clk    (clk),
        .arst_n (arst_n),
        .din    (pin_raw[si]),
        .dout   (pin_s[si])
      );
    end
  endgenerate

  assign {rts_rem_s, rts_loc_s, pri_s, link_up_s} = pin_s;

  spm_sync3 u_sync_tx   (.clk(link_clk), .arst_n(arst_n), .din(tx_data), .dout(tx_s));

  //////////////////////////////////////////////////////////////////////////////
  // registers

  // standby and dce after reset
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ctrl_reg <= `SPM_CTRL_RESET;
    else if (wr_ctrl)
      ctrl_reg <= {25'h0, pwdata[6:0]};
  end

  always_comb
  begin
    wan_q = pwdata[`SPM_DEST_WAN_HI:`SPM_DEST_WAN_LO];
    // writes outside the port range fall back to port 1
    req_port = pwdata[`SPM_DEST_PORT_HI:`SPM_DEST_PORT_LO];
    if (req_port == 4'd0 || req_port > spm_card_limit(pwdata[`SPM_DEST_CNT_HI:`SPM_DEST_CNT_LO]))
      eff_port = `SPM_PORT_DEFAULT;
    else
      eff_port = req_port;
  end

  // destination: wan w1-1..w4-2 as index 0..7, or user card port
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      dest_reg <= {20'h0, `SPM_PORT_DEFAULT, 8'h00};
    else if (wr_dest)
    begin
      dest_reg <= 32'h0000_0000;
      dest_reg[`SPM_DEST_SEL_HI:`SPM_DEST_SEL_LO] <=
        (pwdata[1:0] == 2'h3) ? 2'h0 : pwdata[1:0];
      dest_reg[`SPM_DEST_WAN_HI:`SPM_DEST_WAN_LO]   <= wan_q;
      dest_reg[`SPM_DEST_PORT_HI:`SPM_DEST_PORT_LO] <= eff_port;
      dest_reg[`SPM_DEST_CNT_HI:`SPM_DEST_CNT_LO]   <= pwdata[`SPM_DEST_CNT_HI:`SPM_DEST_CNT_LO];
      dest_reg[`SPM_DEST_SLOT_HI:`SPM_DEST_SLOT_LO] <= pwdata[`SPM_DEST_SLOT_HI:`SPM_DEST_SLOT_LO];
    end
  end

  // per-slot legality mask on the link type
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++)
    begin : g_mask
      assign slot_mask[gi] = slot_legal(5'(gi), ctrl_reg[`SPM_CTRL_E1], ctrl_reg[`SPM_CTRL_SIG]);
    end
  endgenerate

  // any legal pattern kept, illegal bits dropped
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      slots_reg <= 32'h0000_0000;
    else if (wr_slots)
      slots_reg <= pwdata & slot_mask;
    else
      slots_reg <= slots_reg & slot_mask;
  end

  always_comb
  begin
    sty_q = pwdata[`SPM_LOOP_STY_HI:`SPM_LOOP_STY_LO];
    if (sty_q == 2'h3)
      sty_q = 2'h0;
    snd_w = pwdata[`SPM_LOOP_SND_HI:`SPM_LOOP_SND_LO];
    // dds takes off..ds0; v.54 and ft1 only off or on
    if (sty_q == spm_pkg::SPM_STY_DDS)
      snd_ok = (snd_w <= 3'h4) ? snd_w : 3'h0;
    else
      snd_ok = (snd_w == 3'h0) ? 3'h0 : 3'h5;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      loop_reg <= 32'h0000_0000;
    else if (wr_loop)
      loop_reg <= {25'h0, snd_ok, 2'h0, sty_q};
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration handoff to link domain

  assign pend = req_tgl_reg != ack_sync_reg[2];

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ack_sync_reg <= 3'h0;
    else
      ack_sync_reg <= {ack_sync_reg[1:0], ack_tgl};
  end

  // shadow frozen while a handoff is pending; slot set only used on wan
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      req_tgl_reg   <= 1'b0;
      sh_slots_reg  <= 32'h0000_0000;
      sh_active_reg <= 1'b0;
    end
    else if (wr_commit && !pend && ack_sync_reg[1] == ack_sync_reg[2])
    begin
      sh_slots_reg  <= (dest_reg[1:0] == 2'h0) ? slots_reg : 32'h0000_0000;
      sh_active_reg <= ctrl_reg[`SPM_CTRL_ACTIVE];
      req_tgl_reg   <= ~req_tgl_reg;
    end
  end

  spm_link_side u_link
  (
    .link_clk    (link_clk),
    .arst_n      (arst_n),
    .frame_sync  (frame_sync),
    .cfg_req_tgl (req_tgl_reg),
    .cfg_slots   (sh_slots_reg),
    .cfg_active  (sh_active_reg),
    .cfg_ack_tgl (ack_tgl),
    .tx_bit      (tx_s),
    .rx_bit      (rx_link),
    .link_rx_bit (link_rx_bit),
    .link_tx_bit (link_tx_bit),
    .slot_claim  (slot_claim),
    .slot_index  (slot_index)
  );

  assign rx_data = rx_link;

  //////////////////////////////////////////////////////////////////////////////
  // control leads

  assign active = ctrl_reg[`SPM_CTRL_ACTIVE];

  // standby drops rlsd and dsr and holds cts high, link-down rlsd low, configurable cts
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rlsd <= 1'b0;
      dsr  <= 1'b0;
      cts  <= 1'b1;
    end
    else if (!active)
    begin
      rlsd <= 1'b0;
      dsr  <= 1'b0;
      cts  <= 1'b1;
    end
    else
    begin
      rlsd <= link_up_s && (ctrl_reg[`SPM_CTRL_RLSD_RTS] ? rts_rem_s : 1'b1);
      dsr  <= 1'b1;
      unique case (ctrl_reg[`SPM_CTRL_CTS_HI:`SPM_CTRL_CTS_LO])
        2'h0: cts <= 1'b1;
        2'h1: cts <= rts_rem_s;
        2'h2: cts <= 1'b1;
        2'h3: cts <= rts_loc_s;
      endcase
    end
  end

  // presented role follows the mode bit
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      dte_mode <= 1'b0;
    else
      dte_mode <= ctrl_reg[`SPM_CTRL_DTE];
  end

  //////////////////////////////////////////////////////////////////////////////
  // read path

  always_comb
  begin
    rd_val = 32'h0000_0000;
    unique case (paddr)
      `SPM_OFS_CTRL:   rd_val = ctrl_reg;
      `SPM_OFS_DEST:   rd_val = dest_reg;
      `SPM_OFS_SLOTS:  rd_val = slots_reg;
      `SPM_OFS_LOOP:   rd_val = loop_reg;
      // primary-rate flag from pin only, not writable
      `SPM_OFS_STATUS: rd_val = {29'h0, pend, link_up_s, pri_s};
      default:         rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= rd_val;
  end

endmodule

/* File: shared/spm_pkg.sv */
// types shared by the slot mapper modules
package spm_pkg;

  typedef enum logic [1:0] {SPM_DST_WAN, SPM_DST_SERV, SPM_DST_USER} spm_dest_e;
  typedef enum logic [1:0] {SPM_STY_DDS, SPM_STY_V54, SPM_STY_FT1} spm_style_e;
  typedef enum logic [2:0] {SPM_LB_OFF, SPM_LB_OCU, SPM_LB_CSU, SPM_LB_DSU,
                            SPM_LB_DS0, SPM_LB_ON} spm_loop_e;
  typedef enum logic [1:0] {SPM_CTS_PERM, SPM_CTS_RLOCAL, SPM_CTS_IGNOR,
                            SPM_CTS_LOCAL} spm_cts_e;
  typedef logic [31:0] spm_slot_t;

endpackage

/* File: shared/spm_regs.svh */
// register offsets, field positions, reset values and slot counts for the slot mapper
`ifndef SPM_REGS_SVH
`define SPM_REGS_SVH

`define SPM_OFS_CTRL      12'h000
`define SPM_OFS_DEST      12'h004
`define SPM_OFS_SLOTS     12'h008
`define SPM_OFS_LOOP      12'h00C
`define SPM_OFS_COMMIT    12'h010
`define SPM_OFS_STATUS    12'h014

// control fields
`define SPM_CTRL_ACTIVE   0
`define SPM_CTRL_DTE      1
`define SPM_CTRL_E1       2
`define SPM_CTRL_SIG      3
`define SPM_CTRL_CTS_LO   4
`define SPM_CTRL_CTS_HI   5
`define SPM_CTRL_RLSD_RTS 6
`define SPM_CTRL_RESET    32'h0000_0000

// destination fields
`define SPM_DEST_SEL_LO   0
`define SPM_DEST_SEL_HI   1
`define SPM_DEST_WAN_LO   4
`define SPM_DEST_WAN_HI   6
`define SPM_DEST_PORT_LO  8
`define SPM_DEST_PORT_HI  11
`define SPM_DEST_CNT_LO   12
`define SPM_DEST_CNT_HI   14
`define SPM_DEST_SLOT_LO  16
`define SPM_DEST_SLOT_HI  18

// loop fields
`define SPM_LOOP_STY_LO   0
`define SPM_LOOP_STY_HI   1
`define SPM_LOOP_SND_LO   4
`define SPM_LOOP_SND_HI   6

// status fields
`define SPM_STAT_PRI      0
`define SPM_STAT_LINK_UP  1
`define SPM_STAT_PEND     2

`define SPM_T1_SLOTS      5'd24
`define SPM_E1_SLOTS      5'd31
`define SPM_E1_SIG_SLOT   5'd16
`define SPM_FRAME_SLOTS   5'd31
`define SPM_PORT_DEFAULT  4'd1

`endif

/* File: sim/serial_port_slot_mapper_test.sv */
// register, control lead and slot claim tests for the slot mapper
`timescale 1ns/1ps
`include "spm_regs.svh"
module serial_port_slot_mapper_test;
  logic clk = 0, link_clk = 0, arst_n = 0;
  logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, last_err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q, seen, sent;
  logic frame_sync, link_rx_bit, link_tx_bit, slot_claim, rx_data;
  logic [4:0] slot_index;
  logic link_up_pin = 0, pri_link_pin = 0, tx_data = 0, rts_local = 0, rts_remote = 0;
  logic rlsd, dsr, cts, dte_mode;
  int mismatches = 0, num_checks = 0;
  logic [11:0] ta [11];
  logic [31:0] tw [11], te [11];
  logic [7:0] lc [7];
  logic [2:0] li [7], le [7];
  always #10 clk = ~clk;
  initial #7 forever #24 link_clk = ~link_clk;
  always @(negedge link_clk)
  begin
    if (slot_claim === 1'b1)
      seen[slot_index] = 1'b1;
    if (link_tx_bit === 1'b1)
      sent[slot_index] = 1'b1;
  end
  spm_top i_spm_top (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .link_clk(link_clk), .frame_sync(frame_sync),
    .link_rx_bit(link_rx_bit), .link_tx_bit(link_tx_bit), .slot_claim(slot_claim),
    .slot_index(slot_index), .link_up_pin(link_up_pin), .pri_link_pin(pri_link_pin),
    .tx_data(tx_data), .rx_data(rx_data), .rts_local(rts_local),
    .rts_remote(rts_remote), .rlsd(rlsd), .dsr(dsr), .cts(cts), .dte_mode(dte_mode));
  spm_far_end i_spm_far_end (.link_clk(link_clk), .arst_n(arst_n),
    .frame_sync(frame_sync), .link_rx_bit(link_rx_bit));
  ////////////////////////////////////////////////////////////////////////////////
  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    chk("pready", 32'h1, {31'h0, pready});
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("reg", e, q);
  endtask
  task commit_wait;
    int n;
    apb(1'b1, `SPM_OFS_COMMIT, 32'h0000_0001);
    n = 0;
    do
    begin
      apb(1'b0, `SPM_OFS_STATUS, 32'h0);
      n++;
    end
    while (q[`SPM_STAT_PEND] !== 1'b0 && n < 50);
    chk("pend", 32'h0, {31'h0, q[`SPM_STAT_PEND]});
    repeat (100) @(posedge clk);
    seen = 32'h0;
    sent = 32'h0;
    repeat (100) @(posedge clk);
  endtask
  initial
  begin
    #400000;
    mismatches++;
    give_verdict;
  end
  initial
  begin
    ta = '{`SPM_OFS_SLOTS, `SPM_OFS_DEST, `SPM_OFS_DEST, `SPM_OFS_DEST, `SPM_OFS_DEST,
      `SPM_OFS_DEST, `SPM_OFS_LOOP, `SPM_OFS_LOOP, `SPM_OFS_LOOP, `SPM_OFS_LOOP,
      `SPM_OFS_LOOP};
    tw = '{32'h0A42, 32'h0902, 32'h4302, 32'h4002, 32'h0170, 32'h0101, 32'h40, 32'h31,
      32'h02, 32'h23, 32'h50};
    te = '{32'h0A42, 32'h0102, 32'h4302, 32'h4102, 32'h0170, 32'h0101, 32'h40, 32'h51,
      32'h02, 32'h20, 32'h00};
    lc = '{8'h21, 8'h71, 8'h11, 8'h11, 8'h01, 8'h21, 8'h00};
    li = '{3'b101, 3'b100, 3'b101, 3'b100, 3'b100, 3'b001, 3'b101};
    le = '{3'b111, 3'b010, 3'b111, 3'b110, 3'b111, 3'b011, 3'b001};
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    for (int a = 0; a < 24; a += 4)
      rd(a[11:0], (a == `SPM_OFS_DEST) ? 32'h0000_0100 : 32'h0);
    chk("leads", 32'h1, {27'h0, rx_data, dte_mode, rlsd, dsr, cts});
    rd(12'h020, 32'h0);
    chk("pslverr", 32'h1, {31'h0, last_err});
    $display("reset and map test done");
    apb(1'b1, `SPM_OFS_SLOTS, 32'hFFFF_FFFF);
    rd(`SPM_OFS_SLOTS, 32'h01FF_FFFE);
    apb(1'b1, `SPM_OFS_CTRL, 32'h4);
    apb(1'b1, `SPM_OFS_SLOTS, 32'hFFFF_FFFF);
    rd(`SPM_OFS_SLOTS, 32'hFFFF_FFFE);
    apb(1'b1, `SPM_OFS_CTRL, 32'hC);
    rd(`SPM_OFS_SLOTS, 32'hFFFE_FFFE);
    for (int i = 0; i < 11; i++)
    begin
      apb(1'b1, ta[i], tw[i]);
      rd(ta[i], te[i]);
    end
    $display("field test done");
    for (int i = 0; i < 7; i++)
    begin
      link_up_pin <= li[i][2];
      rts_local <= li[i][1];
      rts_remote <= li[i][0];
      apb(1'b1, `SPM_OFS_CTRL, {24'h0, lc[i]});
      repeat (10) @(posedge clk);
      chk("leads", {29'h0, le[i]}, {29'h0, rlsd, dsr, cts});
    end
    apb(1'b1, `SPM_OFS_CTRL, 32'h2);
    repeat (4) @(posedge clk);
    chk("dte", 32'h1, {31'h0, dte_mode});
    $display("lead test done");
    link_up_pin <= 1'b1;
    tx_data <= 1'b1;
    apb(1'b1, `SPM_OFS_CTRL, 32'h1);
    apb(1'b1, `SPM_OFS_DEST, 32'h0100);
    apb(1'b1, `SPM_OFS_SLOTS, 32'h0000_0068);
    commit_wait;
    chk("claims", 32'h68, seen);
    chk("sent", 32'h68, sent);
    chk("rx", 32'h1, {31'h0, rx_data});
    apb(1'b1, `SPM_OFS_CTRL, 32'h0);
    commit_wait;
    chk("claims", 32'h0, seen);
    chk("sent", 32'h0, sent);
    $display("claim test done");
    pri_link_pin <= 1'b1; // primary-rate flag raised at the pin; the status write must not change it
    repeat (10) @(posedge clk);
    apb(1'b1, `SPM_OFS_STATUS, 32'h0000_0004);
    rd(`SPM_OFS_STATUS, 32'h3);
    $display("status test done");
    give_verdict;
  end
endmodule

/* File: sim/spm_checker.sv */
// concurrent checks on the slot mapper top-level ports
`timescale 1ns/1ps
module spm_checker
(
  // clocks and reset
  input wire logic       clk,
  input wire logic       link_clk,
  input wire logic       arst_n,
  // apb
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  // link
  input wire logic       frame_sync,
  input wire logic       link_tx_bit,
  input wire logic       slot_claim,
  input wire logic [4:0] slot_index,
  // leads
  input wire logic       rlsd,
  input wire logic       dsr,
  input wire logic       cts
);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_count;
    !frame_sync && slot_index != 5'd31;
  endsequence
  property p_rdy;
    @(posedge clk) disable iff (!arst_n) psel |-> pready;
  endproperty
  property p_err;
    @(posedge clk) disable iff (!arst_n) pslverr |-> psel && penable;
  endproperty
  property p_sby_cts;
    @(posedge clk) disable iff (!arst_n) !dsr |-> cts;
  endproperty
  property p_sby_rlsd;
    @(posedge clk) disable iff (!arst_n) !dsr |-> !rlsd;
  endproperty
  property p_no_zero;
    @(posedge link_clk) disable iff (!arst_n) slot_claim |-> slot_index != 5'd0;
  endproperty
  property p_tx_gate;
    @(posedge link_clk) disable iff (!arst_n) link_tx_bit |-> slot_claim;
  endproperty
  property p_frame;
    @(posedge link_clk) disable iff (!arst_n) frame_sync |=> slot_index == 5'd0;
  endproperty
  property p_step;
    @(posedge link_clk) disable iff (!arst_n)
      s_count |=> slot_index == $past(slot_index) + 5'd1;
  endproperty
  property p_sat;
    @(posedge link_clk) disable iff (!arst_n)
      (!frame_sync && slot_index == 5'd31) |=> $stable(slot_index);
  endproperty
  a_rdy: assert property (p_rdy) else $error("apb wait state seen");
  a_err: assert property (p_err) else $error("pslverr outside access");
  a_sby_cts: assert property (p_sby_cts) else $error("cts low in standby");
  a_sby_rlsd: assert property (p_sby_rlsd) else $error("rlsd high in standby");
  a_no_zero: assert property (p_no_zero) else $error("slot 0 claimed");
  a_tx_gate: assert property (p_tx_gate) else $error("data outside claim");
  a_frame: assert property (p_frame) else $error("index not 0 after frame");
  a_step: assert property (p_step) else $error("index did not step");
  a_sat: assert property (p_sat) else $error("index not saturated");
endmodule

bind spm_top spm_checker i_spm_checker (.clk(clk), .link_clk(link_clk), .arst_n(arst_n),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .frame_sync(frame_sync), .link_tx_bit(link_tx_bit), .slot_claim(slot_claim),
  .slot_index(slot_index), .rlsd(rlsd), .dsr(dsr), .cts(cts));

/* File: sim/spm_far_end.sv */
// link partner: frame marker every 32 slots and a receive marker bit in slot 6
`timescale 1ns/1ps
module spm_far_end
(
  // link clock and reset
  input wire logic link_clk,
  input wire logic arst_n,
  // link stream
  output logic     frame_sync,
  output logic     link_rx_bit
);
  logic [4:0] cnt_reg;
  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_reg <= 5'h00;
      frame_sync <= 1'b0;
      link_rx_bit <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_reg + 5'h01;
      frame_sync <= (cnt_reg == 5'h1F);
      link_rx_bit <= (cnt_reg == 5'h06);
    end
  end
endmodule
